//--- verilog/pbs_defines.svh
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH
// array geometry defaults
`define PBS_ADDR_W      10
`define PBS_BYTES       4
`define PBS_BYTE_W      9
// pipeline depth from command edge to data cycle
`define PBS_DATA_LAT    2
// burst counter width in bits, giving a burst length of four
`define PBS_BURST_W     2
`endif

//--- verilog/pbs_pkg.sv
`include "pbs_defines.svh"
package pbs_pkg;
    // operation carried in each pipeline stage
    typedef enum logic [1:0] {
        PBS_OP_IDLE  = 2'b00,
        PBS_OP_READ  = 2'b01,
        PBS_OP_WRITE = 2'b10
    } pbs_op_t;
endpackage

//--- verilog/pbs_port.sv
// What this block does
// - strap high: burst address is loaded low bits xor counter 0,1,2,3.
// - strap low: burst low bits step by plus one modulo four.
// - after fourth word the counter wraps to zero, back to loaded address, and continues.
// - inputs other than output_enable_n captured only at rising edge; read data launched from it.
// - selected and enabled, one command per cycle, data two cycles later.
// - load read in n drives addressed word in n+2 while output enable low.
// - advance cycle steps counter, ignores address and read/write inputs.
// - first advance yields second burst address, then successive ones.
// - new load accepted any cycle, no gap after burst.
// - reads and writes alternate back to back, no turnaround cycle.
// - selected only when select_low_a, select_low_b low and select_high high.
// - deselect with load low floats data bus two cycles later.
// - burst advance direction is the one captured at load.
// - clock enable high with rst_n high: edge ignored, all state and bus held.
`timescale 1ns/1ns
`include "pbs_defines.svh"
module pbs_port #(
    parameter int ADDR_W = `PBS_ADDR_W,
    parameter int BYTES  = `PBS_BYTES,
    parameter int BYTE_W = `PBS_BYTE_W
) (
    input  wire logic                      clk,                 // system clock
    input  wire logic                      rst_n,               // synchronous reset, low active
    input  wire logic [ADDR_W-1:0]         addr,                // external address
    input  wire logic                      read_not_write,      // high read, low write
    input  wire logic                      advance_or_load,     // high advance, low load
    input  wire logic [BYTES-1:0]          byte_write_strobe_n, // per byte write, low active
    input  wire logic                      chip_select_low_a,   // first select, low active
    input  wire logic                      chip_select_high,    // second select, high active
    input  wire logic                      chip_select_low_b,   // third select, low active
    input  wire logic                      clock_enable_n,      // low: edge takes effect
    input  wire logic                      output_enable_n,     // asynchronous read drive gate
    input  wire logic                      burst_order_strap,   // high interleaved, low linear
    input  wire logic [BYTES*BYTE_W-1:0]   data_in,             // data bus as seen at pins
    output logic      [BYTES*BYTE_W-1:0]   data_out,            // read data driven on bus
    output logic                           data_oe_n            // low while device drives bus
);
    import pbs_pkg::*;

    localparam int DW = BYTES * BYTE_W;
    localparam int BW = `PBS_BURST_W;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [ADDR_W-1:0] base;       // loaded address
        logic [BW-1:0]     cnt;        // burst step counter
        pbs_op_t           burst_op;   // direction of the running burst
        pbs_op_t           op1;        // stage one operation
        logic [ADDR_W-1:0] a1;
        logic [BYTES-1:0]  be1;
        pbs_op_t           op2;        // stage two: data cycle
        logic [ADDR_W-1:0] a2;
        logic [BYTES-1:0]  be2;
        logic [DW-1:0]     rdata;
    } pbs_state_t;

    pbs_state_t st_reg, st_next;
    logic [DW-1:0] mem [0:(1<<ADDR_W)-1];

    // burst address for a given step
    function automatic logic [ADDR_W-1:0] pbs_burst_addr(input logic [ADDR_W-1:0] b,
                                                         input logic [BW-1:0] c,
                                                         input logic strap);
        logic [ADDR_W-1:0] r;
        r = b;
        if (strap)
            r[BW-1:0] = b[BW-1:0] ^ c;
        else
            r[BW-1:0] = BW'(b[BW-1:0] + c);
        return r;
    endfunction

    logic selected;
    logic [ADDR_W-1:0] adv_addr;
    logic [BW-1:0] cnt_inc;
    assign selected = !chip_select_low_a && chip_select_high && !chip_select_low_b;
    assign cnt_inc  = BW'(st_reg.cnt + 1'b1);   // natural wrap to zero after fourth
    assign adv_addr = pbs_burst_addr(st_reg.base, cnt_inc, burst_order_strap);

    ////////////////////////////////////////////////////////////////////////////////
    // next-state: command decode and two-stage pipeline
    always_comb begin
        st_next = st_reg;
        if (!clock_enable_n) begin                              // else hold everything
            // stage two takes stage one regardless of new command
            st_next.op2 = st_reg.op1;
            st_next.a2  = st_reg.a1;
            st_next.be2 = st_reg.be1;
            if (st_reg.op1 == PBS_OP_READ) begin
                st_next.rdata = mem[st_reg.a1];                 // launched at edge
                // a write in its data cycle to the same word lands at this same edge,
                // so its enabled bytes are passed straight on; otherwise the read sees stale data
                if (st_reg.op2 == PBS_OP_WRITE && st_reg.a2 == st_reg.a1) begin
                    for (int b = 0; b < BYTES; b++) begin
                        if (!st_reg.be2[b])
                            st_next.rdata[b*BYTE_W +: BYTE_W] = data_in[b*BYTE_W +: BYTE_W];
                    end
                end
            end
            if (advance_or_load) begin
                // address and read/write ignored direction from load
                st_next.cnt = cnt_inc;
                st_next.op1 = st_reg.burst_op;                  // idle if no burst
                st_next.a1  = adv_addr;
                st_next.be1 = byte_write_strobe_n;
            end else if (selected) begin
                // new load, no gap
                st_next.base     = addr;
                st_next.cnt      = '0;
                st_next.burst_op = read_not_write ? PBS_OP_READ : PBS_OP_WRITE;
                st_next.op1      = st_next.burst_op;
                st_next.a1       = addr;
                st_next.be1      = byte_write_strobe_n;
            end else begin
                st_next.burst_op = PBS_OP_IDLE;                 // deselect stops burst
                st_next.op1      = PBS_OP_IDLE;
            end
        end
        if (!rst_n) begin
            st_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // array write: data cycle of a write stores masked bytes
    genvar gi;
    generate
        for (gi = 0; gi < BYTES; gi++) begin : g_byte
            always_ff @(posedge clk) begin
                if (rst_n && !clock_enable_n && st_reg.op2 == PBS_OP_WRITE && !st_reg.be2[gi])
                    mem[st_reg.a2][gi*BYTE_W +: BYTE_W] <= data_in[gi*BYTE_W +: BYTE_W];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // bus drive: read data cycle gated by asynchronous output enable
    assign data_out  = st_reg.rdata;
    assign data_oe_n = !(st_reg.op2 == PBS_OP_READ && !output_enable_n);

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    read_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && !advance_or_load && selected && read_not_write)
        ##1 !clock_enable_n |=> st_reg.op2 == PBS_OP_READ)
        else $error("read not in data stage two cycles later");
    deselect_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && !advance_or_load && !selected) ##1 !clock_enable_n |=> data_oe_n)
        else $error("bus driven after deselect");
    suspend_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        clock_enable_n |=> st_reg == $past(st_reg))
        else $error("state changed on suspended edge");
    burst_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && advance_or_load) |=> st_reg.op1 == $past(st_reg.burst_op))
        else $error("advance took wrong direction");
    wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && advance_or_load && st_reg.cnt == 2'd3) |=> st_reg.cnt == 2'd0)
        else $error("burst counter did not wrap");
    load_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && !advance_or_load && selected) |=> st_reg.a1 == $past(addr))
        else $error("load address not captured");
    adv_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && advance_or_load && st_reg.cnt == 2'd0 && !burst_order_strap)
        |=> st_reg.a1[1:0] == 2'($past(st_reg.base[1:0]) + 2'd1))
        else $error("first advance not loaded plus one");
    // a read leaving stage one must drive the bus in the next cycle when output enable is low
    drive_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && st_reg.op1 == PBS_OP_READ) ##1 !output_enable_n |-> !data_oe_n)
        else $error("read data cycle without bus drive");
    // read data is the array word, unless a same-word write is in its data cycle
    read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && st_reg.op1 == PBS_OP_READ
         && !(st_reg.op2 == PBS_OP_WRITE && st_reg.a2 == st_reg.a1))
        |=> st_reg.rdata == $past(mem[st_reg.a1]))
        else $error("read data not taken from array");
    // full-word write followed at once by a read of the same word hands on the bus value
    forward_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && st_reg.op1 == PBS_OP_READ && st_reg.op2 == PBS_OP_WRITE
         && st_reg.a2 == st_reg.a1 && st_reg.be2 == '0)
        |=> st_reg.rdata == $past(data_in))
        else $error("read after write returned stale data");
    // every effective edge moves stage one into the data stage
    pipe_move_a: assert property (@(posedge clk) disable iff (!rst_n)
        !clock_enable_n |=> (st_reg.op2 == $past(st_reg.op1) && st_reg.a2 == $past(st_reg.a1)))
        else $error("pipeline stage not carried on");
    // deselect ends the burst and starts nothing
    deselect_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && !advance_or_load && !selected)
        |=> (st_reg.op1 == PBS_OP_IDLE && st_reg.burst_op == PBS_OP_IDLE))
        else $error("deselect started an operation");
    // an advance with no running burst is a no-operation
    idle_advance_cycle_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && advance_or_load && st_reg.burst_op == PBS_OP_IDLE)
        |=> st_reg.op1 == PBS_OP_IDLE)
        else $error("advance after deselect did something");
    // the load command fixes the direction of the whole burst
    load_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && !advance_or_load && selected)
        |=> st_reg.burst_op == ($past(read_not_write) ? PBS_OP_READ : PBS_OP_WRITE))
        else $error("burst direction not captured at load");
    // interleaved order: low bits are loaded bits xor the step count
    inter_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && advance_or_load && burst_order_strap)
        |=> st_reg.a1[1:0] == ($past(st_reg.base[1:0]) ^ 2'($past(st_reg.cnt) + 2'd1)))
        else $error("interleaved burst address wrong");
    // linear order: low bits are loaded bits plus the step count, modulo four
    linear_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && advance_or_load && !burst_order_strap)
        |=> st_reg.a1[1:0] == 2'($past(st_reg.base[1:0]) + $past(st_reg.cnt) + 2'd1))
        else $error("linear burst address wrong");
    // bursts never leave the loaded four-word block
    upper_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && advance_or_load)
        |=> st_reg.a1[ADDR_W-1:2] == $past(st_reg.base[ADDR_W-1:2]))
        else $error("burst left its block");
    // reset leaves the pipeline empty and the bus released
    reset_idle_a: assert property (@(posedge clk)
        !rst_n |=> (st_reg.op2 == PBS_OP_IDLE && st_reg.op1 == PBS_OP_IDLE && data_oe_n))
        else $error("pipeline busy after reset");
    cov_forward_c: cover property (@(posedge clk) disable iff (!rst_n)
        !clock_enable_n && st_reg.op1 == PBS_OP_READ && st_reg.op2 == PBS_OP_WRITE && st_reg.a2 == st_reg.a1);
    cov_idle_advance_cycle_c: cover property (@(posedge clk) disable iff (!rst_n)
        !clock_enable_n && advance_or_load && st_reg.burst_op == PBS_OP_IDLE);
    cov_burst_c: cover property (@(posedge clk) disable iff (!rst_n)
        (!clock_enable_n && advance_or_load)[*4]);
    cov_rw_c: cover property (@(posedge clk) disable iff (!rst_n)
        st_reg.op2 == PBS_OP_WRITE ##1 st_reg.op2 == PBS_OP_READ ##1 st_reg.op2 == PBS_OP_WRITE);
    cov_suspend_c: cover property (@(posedge clk) disable iff (!rst_n)
        st_reg.op2 == PBS_OP_READ && clock_enable_n);
endmodule

//--- tb/pbs_ctrl_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
module pbs_ctrl_model (
    input  wire logic        clk,       // system clock
    input  wire logic        drive_en,  // controller drives write data this cycle
    input  wire logic [35:0] wdata,     // controller write data
    input  wire logic [35:0] data_out,  // device read data
    input  wire logic        data_oe_n, // device drives bus, low active
    output logic      [35:0] bus        // resolved bus level seen at the pins
);
    logic [35:0] last_reg;              // last resolved bus value
    // a released bus shows the inverse of its last value, never a stale copy
    always_comb begin
        if (!data_oe_n) bus = data_out;
        else if (drive_en) bus = wdata;
        else bus = ~last_reg;
    end
    // remember the bus for the released case
    always_ff @(posedge clk) last_reg <= bus;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic        clk, rst_n, adv, rnw, cen_n, strap, drv, oe_n;
    logic [2:0]  cs;
    logic [9:0]  addr;
    logic [35:0] wd, bus, dout;
    logic [1:0]  kind [0:63];
    logic [35:0] dat [0:63];
    logic [35:0] w [0:3];
    int          n, i, failures, checked, cycles;
    // device under test, selects ordered {low_a, high, low_b}
    pbs_port dut (.clk(clk), .rst_n(rst_n), .addr(addr), .read_not_write(rnw), .advance_or_load(adv),
        .byte_write_strobe_n(4'h0), .chip_select_low_a(cs[2]), .chip_select_high(cs[1]),
        .chip_select_low_b(cs[0]), .clock_enable_n(cen_n), .output_enable_n(1'b0),
        .burst_order_strap(strap), .data_in(bus), .data_out(dout), .data_oe_n(oe_n));
    pbs_ctrl_model ctrl (.clk(clk), .drive_en(drv), .wdata(wd), .data_out(dout), .data_oe_n(oe_n), .bus(bus));
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp_data(input string what, input logic [35:0] exp, input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    // one bus cycle: check the slot due now, drive a command, book its data slot two cycles on
    task automatic step(input logic a_l, input logic rw, input logic [9:0] a, input logic [2:0] c,
                        input logic ce, input logic [1:0] k, input logic [35:0] d);
        @(negedge clk);
        cmp_bit("data_oe_n", kind[n] != 2'd1, oe_n);
        if (kind[n] == 2'd1) cmp_data("data_out", dat[n], dout);
        drv = (kind[n] == 2'd2);
        wd = dat[n];
        adv = a_l;
        rnw = rw;
        addr = a;
        cs = c;
        cen_n = ce;
        if (!ce) begin
            kind[n+2] = k;
            dat[n+2] = d;
            n++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 500) begin
            failures++;
            tally_and_finish();
        end
    end
    // test sequence, inputs change at the falling edge
    initial begin
        {rst_n, adv, rnw, cen_n, strap, drv, addr, wd, n} = '0;
        cs = 3'b110; // deselected until the first step, no stray command after reset
        for (i = 0; i < 64; i++) kind[i] = 2'd0;
        for (i = 0; i < 4; i++) w[i] = {9'h1A5, 9'h0C3, 9'h15A, 9'(i)};
        repeat (3) @(negedge clk);
        rst_n = 1;
        step(0, 0, 10'h005, 3'b010, 0, 2, w[0]);
        for (i = 1; i < 4; i++) step(1, 1, 10'h3FF, 3'b010, 0, 2, w[i]);
        step(0, 1, 10'h005, 3'b010, 0, 1, w[0]);
        for (i = 1; i < 5; i++) step(1, 0, 10'h000, 3'b010, 0, 1, w[i%4]);
        step(1, 0, 10'h000, 3'b010, 1, 0, 0);
        step(0, 1, 10'h005, 3'b110, 0, 0, 0);
        step(1, 1, 10'h005, 3'b010, 0, 0, 0);
        $display("test linear burst done");
        strap = 1;
        step(0, 1, 10'h005, 3'b010, 0, 1, w[0]);
        for (i = 1; i < 4; i++) step(1, 1, 10'h000, 3'b010, 0, 1, w[4-i]);
        step(0, 1, 10'h005, 3'b000, 0, 0, 0);
        step(0, 1, 10'h005, 3'b011, 0, 0, 0);
        step(0, 0, 10'h200, 3'b010, 0, 2, ~w[2]);
        step(0, 1, 10'h006, 3'b010, 0, 1, w[1]);
        step(0, 0, 10'h201, 3'b010, 0, 2, ~w[3]);
        step(0, 1, 10'h200, 3'b010, 0, 1, ~w[2]);
        step(0, 0, 10'h201, 3'b010, 0, 2, w[1]);
        step(0, 1, 10'h201, 3'b010, 0, 1, w[1]);
        repeat (3) step(0, 1, 10'h000, 3'b110, 0, 0, 0);
        $display("test interleaved and mixed done");
        tally_and_finish();
    end
endmodule
